// [src/tmo_pkg.sv]
package tmo_pkg;

    // Register byte offsets on the AHB-Lite window
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PRESC = 8'h04;
    localparam logic [7:0] ADDR_OUTCTL = 8'h08;
    localparam logic [7:0] ADDR_ONESHOT = 8'h0c;
    localparam logic [7:0] ADDR_CMP_A = 8'h10;
    localparam logic [7:0] ADDR_CMP_B = 8'h14;
    localparam logic [7:0] ADDR_CAPTURE = 8'h18;
    localparam logic [7:0] ADDR_COUNT = 8'h1c;
    localparam logic [7:0] ADDR_FLAGS = 8'h20;

    // Output behaviour of the two timer pins
    typedef enum logic [1:0] {
        MODE_PWM,
        MODE_PPG,
        MODE_ONESHOT,
        MODE_IDLE
    } tmo_mode_t;

    // Counter control word, bit 0 is the run bit
    typedef struct packed {
        logic [1:0] edge_sel;                  // 0 none, 1 rise, 2 fall, 3 both
        logic event_mode;                      // Count capture edges instead of ticks
        logic clear_on_second_match_bit;       // Clear counter on compare B match
        logic count_run_bit;                   // Counter runs while set
    } tmo_ctrl_t;

    // Timer output control word
    typedef struct packed {
        tmo_mode_t mode;                       // Shared output mode
        logic alv_b;                           // Active level of output B
        logic en_b;                            // Output B enable
        logic alv_a;                           // Active level of output A
        logic en_a;                            // Output A enable
    } tmo_outctl_t;

    localparam int CTRL_W = 5;
    localparam int OUTCTL_W = 6;
    localparam tmo_ctrl_t CTRL_RST = '0;
    localparam tmo_outctl_t OUTCTL_RST = '{mode: MODE_IDLE, default: 1'b0};
    localparam logic [3:0] PRESC_RST = 4'h0;

    // Capture edge selections
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // One-shot command bits (write-only)
    localparam int OS_START_A = 0;
    localparam int OS_START_B = 1;
    localparam int OS_RESET_A = 2;
    localparam int OS_RESET_B = 3;

    // Sticky flag bits, write one to clear
    localparam int FLG_MATCH_A = 0;
    localparam int FLG_MATCH_B = 1;
    localparam int FLG_EDGE = 2;

    // Prescaler: divide by PRESC_BASE shifted by the select, select capped
    localparam logic [10:0] PRESC_BASE = 11'h004;
    localparam logic [3:0] PRESC_SEL_MAX = 4'h8;

    // Capture input phases shorter than this many clocks are filtered out
    localparam int CAP_MIN_PHASE = 3;

endpackage

// [src/tmo_timer.sv]
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module tmo_timer #(
    parameter int CNT_W = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic capture_edge_input,
    output logic pulse_out_a,
    output logic pulse_out_b
);

    // The logic is written for a counter of 2 to 16 bits sitting in one bus word
    if (CNT_W < 2 || CNT_W > 16) begin : g_bad_width
        $error("tmo_timer: CNT_W must lie between 2 and 16");
    end

    // Software-visible state
    tmo_pkg::tmo_ctrl_t ctrl_r;                // Counter control
    tmo_pkg::tmo_outctl_t outctl_r;            // Output control
    logic [3:0] presc_sel_r;                   // Prescaler select
    logic [CNT_W-1:0] cmp_r [2];               // Compare A and B
    logic [CNT_W-1:0] cap_r;                   // Edge capture value
    logic [CNT_W-1:0] cnt_r;                   // Main up counter
    logic [2:0] flag_r;                        // Sticky event flags

    // Bus pipeline
    logic wr_pend_r;                           // Write data phase pending
    logic [7:0] wr_addr_r;                     // Address of pending write
    logic rd_take;
    logic wr_take;
    logic [31:0] rd_nxt;

    // Count engine
    logic [9:0] presc_cnt_r;
    logic [3:0] sel_eff;
    logic [9:0] div_m1;
    logic tick;
    logic step;
    logic armed_r;                             // First event edge seen
    logic [CNT_W-1:0] cnt_nxt;
    logic wrap;
    logic match [2];
    logic run_stop_wr;

    // Capture input conditioning
    logic sync0_r;
    logic sync1_r;
    logic [1:0] hist_r;
    logic filt_r;
    logic edge_hit_r;                          // One-cycle valid edge
    logic rise_ok;
    logic fall_ok;

    // Per-channel write strobes and output state
    logic wr_cmp [2];
    logic start_wr [2];
    logic reset_wr [2];
    logic act_r [2];                           // 1 while output is active
    logic pin_r [2];

    // Address phase is taken on hready, all transfers zero-wait
    assign rd_take = hsel && hready && htrans[1] && !hwrite;
    assign wr_take = hsel && hready && htrans[1] && hwrite;

    // Read mux in the address phase, so hrdata is a plain register
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (haddr[7:0])
            tmo_pkg::ADDR_CTRL: rd_nxt[tmo_pkg::CTRL_W-1:0] = ctrl_r;
            tmo_pkg::ADDR_PRESC: rd_nxt[3:0] = presc_sel_r;
            tmo_pkg::ADDR_OUTCTL: rd_nxt[tmo_pkg::OUTCTL_W-1:0] = outctl_r;
            tmo_pkg::ADDR_CMP_A: rd_nxt[CNT_W-1:0] = cmp_r[0];
            tmo_pkg::ADDR_CMP_B: rd_nxt[CNT_W-1:0] = cmp_r[1];
            tmo_pkg::ADDR_CAPTURE: rd_nxt[CNT_W-1:0] = cap_r;
            tmo_pkg::ADDR_COUNT: rd_nxt[CNT_W-1:0] = cnt_r;
            tmo_pkg::ADDR_FLAGS: rd_nxt[2:0] = flag_r;
            default: rd_nxt = 32'h0000_0000; // Unmapped and one-shot read zero
        endcase
    end

    // Bus answer registers; response is always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (rd_take) begin
                hrdata <= rd_nxt;
            end
        end
    end

    // Hold the write address until its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= wr_take;
            if (wr_take) begin
                wr_addr_r <= haddr[7:0];
            end
        end
    end

    // Write strobes in the data phase
    assign wr_cmp[0] = wr_pend_r && wr_addr_r == tmo_pkg::ADDR_CMP_A;
    assign wr_cmp[1] = wr_pend_r && wr_addr_r == tmo_pkg::ADDR_CMP_B;
    assign start_wr[0] = wr_pend_r && wr_addr_r == tmo_pkg::ADDR_ONESHOT
        && hwdata[tmo_pkg::OS_START_A];
    assign start_wr[1] = wr_pend_r && wr_addr_r == tmo_pkg::ADDR_ONESHOT
        && hwdata[tmo_pkg::OS_START_B];
    assign reset_wr[0] = wr_pend_r && wr_addr_r == tmo_pkg::ADDR_ONESHOT
        && hwdata[tmo_pkg::OS_RESET_A];
    assign reset_wr[1] = wr_pend_r && wr_addr_r == tmo_pkg::ADDR_ONESHOT
        && hwdata[tmo_pkg::OS_RESET_B];
    assign run_stop_wr = wr_pend_r && wr_addr_r == tmo_pkg::ADDR_CTRL && !hwdata[0];

    // Configuration registers; changing them while running is not guarded
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= tmo_pkg::CTRL_RST;
            outctl_r <= tmo_pkg::OUTCTL_RST;
            presc_sel_r <= tmo_pkg::PRESC_RST;
        end else if (wr_pend_r) begin
            if (wr_addr_r == tmo_pkg::ADDR_CTRL) begin
                ctrl_r <= tmo_pkg::tmo_ctrl_t'(hwdata[tmo_pkg::CTRL_W-1:0]);
            end
            if (wr_addr_r == tmo_pkg::ADDR_OUTCTL) begin
                outctl_r <= tmo_pkg::tmo_outctl_t'(hwdata[tmo_pkg::OUTCTL_W-1:0]);
            end
            if (wr_addr_r == tmo_pkg::ADDR_PRESC) begin
                presc_sel_r <= hwdata[3:0];
            end
        end
    end

    // Compare registers; reset value is arbitrary all-ones
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_r[0] <= '1;
            cmp_r[1] <= '1;
        end else begin
            if (wr_cmp[0]) begin
                cmp_r[0] <= hwdata[CNT_W-1:0];
            end
            if (wr_cmp[1]) begin
                cmp_r[1] <= hwdata[CNT_W-1:0];
            end
        end
    end

    // Prescaler: selects above the top value clamp to divide by 1024
    assign sel_eff = (presc_sel_r > tmo_pkg::PRESC_SEL_MAX) ? tmo_pkg::PRESC_SEL_MAX
        : presc_sel_r;
    assign div_m1 = 10'((tmo_pkg::PRESC_BASE << sel_eff) - 11'h001);
    assign tick = ctrl_r.count_run_bit && presc_cnt_r == div_m1;

    // Held at zero while stopped, so the first tick lands a full count later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_cnt_r <= 10'h000;
        end else if (!ctrl_r.count_run_bit || presc_cnt_r == div_m1) begin
            presc_cnt_r <= 10'h000;
        end else begin
            presc_cnt_r <= presc_cnt_r + 10'h001;
        end
    end

    // Event mode swallows the first edge so one edge still reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            armed_r <= 1'b0;
        end else if (!ctrl_r.count_run_bit) begin
            armed_r <= 1'b0;
        end else if (edge_hit_r) begin
            armed_r <= 1'b1;
        end
    end

    assign step = ctrl_r.count_run_bit
        && (ctrl_r.event_mode ? (edge_hit_r && armed_r) : tick);

    // Free-running wraps through the full range; clear mode ends at compare B
    assign cnt_nxt = (ctrl_r.clear_on_second_match_bit && cnt_r == cmp_r[1]) ? '0
        : cnt_r + 1'b1;
    assign wrap = step && cnt_nxt == '0;

    // Counter stops on the stopping write even when a match lands with it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
        end else if (step && !run_stop_wr) begin
            cnt_r <= cnt_nxt;
        end
    end

    // Capture pin synchroniser; stage 0 feeds stage 1 only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync0_r <= 1'b0;
            sync1_r <= 1'b0;
        end else begin
            sync0_r <= capture_edge_input;
            sync1_r <= sync0_r;
        end
    end

    // Level accepted only after CAP_MIN_PHASE equal samples
    assign rise_ok = ctrl_r.edge_sel == tmo_pkg::EDGE_RISE
        || ctrl_r.edge_sel == tmo_pkg::EDGE_BOTH;
    assign fall_ok = ctrl_r.edge_sel == tmo_pkg::EDGE_FALL
        || ctrl_r.edge_sel == tmo_pkg::EDGE_BOTH;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hist_r <= 2'h0;
            filt_r <= 1'b0;
            edge_hit_r <= 1'b0;
        end else begin
            hist_r <= {hist_r[0], sync1_r};
            edge_hit_r <= 1'b0;
            if (sync1_r == hist_r[0] && sync1_r == hist_r[1] && sync1_r != filt_r) begin
                filt_r <= sync1_r;
                edge_hit_r <= sync1_r ? rise_ok : fall_ok;
            end
        end
    end

    // Capture holds the running count at each valid edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_r <= '0;
        end else if (edge_hit_r) begin
            cap_r <= cnt_r;
        end
    end

    // Sticky flags: hardware set beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= 3'h0;
        end else begin
            if (wr_pend_r && wr_addr_r == tmo_pkg::ADDR_FLAGS) begin
                flag_r <= (flag_r & ~hwdata[2:0]) | {edge_hit_r, match[1], match[0]};
            end else begin
                flag_r <= flag_r | {edge_hit_r, match[1], match[0]};
            end
        end
    end

    // One copy of the compare and output logic per channel
    for (genvar i = 0; i < 2; i++) begin : g_chan
        logic en;
        logic alv;
        logic act_nxt;

        // Match only when the counter steps, and never during its own write
        assign match[i] = step && cnt_nxt == cmp_r[i] && !wr_cmp[i];
        assign en = (i == 0) ? outctl_r.en_a : outctl_r.en_b;
        assign alv = (i == 0) ? outctl_r.alv_a : outctl_r.alv_b;

        // Next activity of the output
        always_comb begin
            act_nxt = act_r[i];
            unique case (outctl_r.mode)
                tmo_pkg::MODE_ONESHOT: begin
                    // Level kept while stopped, only commands and matches move it
                    if (start_wr[i]) begin
                        act_nxt = 1'b1;
                    end else if (reset_wr[i]) begin
                        act_nxt = 1'b0;
                    end else if (match[i]) begin
                        act_nxt = 1'b0;
                    end
                end
                tmo_pkg::MODE_PWM, tmo_pkg::MODE_PPG: begin
                    if (outctl_r.mode == tmo_pkg::MODE_PPG && i == 1) begin
                        act_nxt = 1'b0; // PPG drives output A only
                    end else if (!ctrl_r.count_run_bit) begin
                        act_nxt = 1'b1;
                    end else if (wrap) begin
                        act_nxt = 1'b1;
                    end else if (match[i]) begin
                        act_nxt = 1'b0;
                    end
                end
                tmo_pkg::MODE_IDLE: begin
                    act_nxt = 1'b0;
                end
            endcase
        end

        // Output flop; a disabled output shows the inverse of its active select
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                act_r[i] <= 1'b0;
                pin_r[i] <= 1'b1;
            end else begin
                act_r[i] <= act_nxt;
                pin_r[i] <= (en && act_nxt) ? alv : !alv;
            end
        end
    end

    assign pulse_out_a = pin_r[0];
    assign pulse_out_b = pin_r[1];

    // Checks

    a_disabled_level: assert property (@(posedge hclk) disable iff (!hresetn)
        !outctl_r.en_a |=> pulse_out_a == !$past(outctl_r.alv_a))
        else $error("disabled output A not at inverse level");

    a_ppg_stop_active: assert property (@(posedge hclk) disable iff (!hresetn)
        outctl_r.mode == tmo_pkg::MODE_PPG && !ctrl_r.count_run_bit && outctl_r.en_a
        |=> pulse_out_a == $past(outctl_r.alv_a))
        else $error("stopped PPG output A not active");

    a_oneshot_start: assert property (@(posedge hclk) disable iff (!hresetn)
        outctl_r.mode == tmo_pkg::MODE_ONESHOT && start_wr[1] |=> act_r[1])
        else $error("one-shot start did not activate output B");

    a_oneshot_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        outctl_r.mode == tmo_pkg::MODE_ONESHOT && reset_wr[0] && !start_wr[0] |=> !act_r[0])
        else $error("one-shot reset did not clear output A");

    a_oneshot_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        outctl_r.mode == tmo_pkg::MODE_ONESHOT && !ctrl_r.count_run_bit
        && !start_wr[0] && !reset_wr[0] |=> $stable(act_r[0]))
        else $error("stopped one-shot output A changed");

    a_match_flag_sets: assert property (@(posedge hclk) disable iff (!hresetn)
        match[0] |=> flag_r[tmo_pkg::FLG_MATCH_A] [*2])
        else $error("match A flag not held");

    a_cmp_write_mute: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_cmp[1] |-> !match[1])
        else $error("match B seen during compare B write");

    a_start_delay: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(ctrl_r.count_run_bit) |-> !tick [*3])
        else $error("count tick within three clocks of start");

    a_capture_copy: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_hit_r |=> cap_r == $past(cnt_r))
        else $error("capture did not take the counter");

    a_filter_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(filt_r) |-> $past(sync1_r, 1) == filt_r && $past(sync1_r, 3) == filt_r)
        else $error("capture filter passed a short phase");

    a_clear_interval: assert property (@(posedge hclk) disable iff (!hresetn)
        step && !run_stop_wr && ctrl_r.clear_on_second_match_bit && cnt_r == cmp_r[1]
        |=> cnt_r == '0)
        else $error("counter not cleared on compare B");

    c_oneshot_pulse: cover property (@(posedge hclk) disable iff (!hresetn)
        start_wr[0] ##[1:300] (match[0] && outctl_r.mode == tmo_pkg::MODE_ONESHOT));
    c_ppg_wrap: cover property (@(posedge hclk) disable iff (!hresetn)
        outctl_r.mode == tmo_pkg::MODE_PPG && wrap);
    c_capture_edge: cover property (@(posedge hclk) disable iff (!hresetn) edge_hit_r);
    c_stop_on_match: cover property (@(posedge hclk) disable iff (!hresetn)
        run_stop_wr && match[0]);

endmodule // tmo_timer

// [sim/tmo_pulse_src.sv]
`timescale 1ns/1ns
// Far side of the timer: a pulse source on the capture pin and a load on output A
module tmo_pulse_src (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pulse_req,
    input wire logic [15:0] pulse_len,
    output logic capture_edge_input,
    input wire logic pulse_out_a,
    output logic [15:0] a_rises,
    output logic [15:0] a_period,
    output logic [15:0] a_high
);
    logic [15:0] left_r; // Clocks of high phase still to send
    logic [15:0] since_rise_r; // Clocks since the last rise of output A
    logic a_prev_r; // Output A one clock ago

    // Source: high for pulse_len clocks, idle low; a short request breaks the minimum on purpose
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_r <= 16'h0000;
            capture_edge_input <= 1'b0;
        end else if (pulse_req) begin
            left_r <= pulse_len;
            capture_edge_input <= 1'b1;
        end else if (left_r > 16'h0001) begin
            left_r <= left_r - 16'h0001;
        end else begin
            left_r <= 16'h0000;
            capture_edge_input <= 1'b0;
        end
    end

    // Load: measures period and high time of output A in system clocks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_prev_r <= 1'b1;
            since_rise_r <= 16'h0000;
            a_rises <= 16'h0000;
            a_period <= 16'h0000;
            a_high <= 16'h0000;
        end else begin
            a_prev_r <= pulse_out_a;
            since_rise_r <= since_rise_r + 16'h0001;
            // Rising edge closes one period
            if (pulse_out_a && !a_prev_r) begin
                a_period <= since_rise_r + 16'h0001;
                since_rise_r <= 16'h0000;
                a_rises <= a_rises + 16'h0001;
            end
            // Falling edge closes the high phase
            if (!pulse_out_a && a_prev_r) begin
                a_high <= since_rise_r + 16'h0001;
            end
        end
    end
endmodule // tmo_pulse_src

// [sim/testbench.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdat, d1;
    logic [1:0] htrans;
    logic capture_edge_input, pulse_out_a, pulse_out_b, preq;
    logic [15:0] plen, rises, per, high, base;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    tmo_timer u_tmo_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .capture_edge_input(capture_edge_input), .pulse_out_a(pulse_out_a),
        .pulse_out_b(pulse_out_b));

    tmo_pulse_src u_tmo_pulse_src (.hclk(hclk), .hresetn(hresetn), .pulse_req(preq),
        .pulse_len(plen), .capture_edge_input(capture_edge_input), .pulse_out_a(pulse_out_a),
        .a_rises(rises), .a_period(per), .a_high(high));

    // 50 MHz system clock
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Hang guard, well above the longest expected run
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 80000) begin
            failures++;
            close_out();
        end
    end

    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // One AHB-Lite single word transfer; read data lands in rdat
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdat = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 32'h00000000);
    endtask

    // Lets a write's effect reach the pins before they are looked at
    task automatic settle;
        repeat (2) @(posedge hclk);
        #1;
    endtask

    // Asks the source for one high phase, then waits wt clocks
    task automatic pulse(input logic [15:0] len, input int wt);
        @(posedge hclk);
        preq <= 1'b1;
        plen <= len;
        @(posedge hclk);
        preq <= 1'b0;
        repeat (wt) @(posedge hclk);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        preq = 1'b0;
        plen = 16'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        // Disabled outputs with active-low select idle high
        `CHK({pulse_out_a, pulse_out_b}, 2'b11)
        rd(tmo_pkg::ADDR_OUTCTL);
        `CHK(rdat, 32'h00000030)
        rd(8'h24);
        `CHK(rdat, 32'h00000000)
        $display("test reset done");

        // Event mode: first edge is absorbed, the flag tells it apart
        wr(tmo_pkg::ADDR_CTRL, 32'h0000000d);
        rd(tmo_pkg::ADDR_COUNT);
        `CHK(rdat, 32'h00000000)
        pulse(16'd10, 30);
        rd(tmo_pkg::ADDR_COUNT);
        `CHK(rdat, 32'h00000000)
        rd(tmo_pkg::ADDR_FLAGS);
        `CHK(rdat[tmo_pkg::FLG_EDGE], 1'b1)
        pulse(16'd10, 30);
        rd(tmo_pkg::ADDR_COUNT);
        `CHK(rdat, 32'h00000001)
        wr(tmo_pkg::ADDR_CTRL, 32'h0);
        wr(tmo_pkg::ADDR_FLAGS, 32'h7);
        $display("test event done");

        // Disabled outputs with active-high select sit low
        wr(tmo_pkg::ADDR_OUTCTL, 32'h0000000a);
        settle();
        `CHK({pulse_out_a, pulse_out_b}, 2'b00)
        $display("test disable done");

        // One-shot on both channels, active low
        wr(tmo_pkg::ADDR_PRESC, 32'h0);
        wr(tmo_pkg::ADDR_CMP_A, 32'h5);
        wr(tmo_pkg::ADDR_CMP_B, 32'h40);
        wr(tmo_pkg::ADDR_OUTCTL, 32'h00000025);
        // Both outputs forced inactive first, so the start below really moves them
        wr(tmo_pkg::ADDR_ONESHOT, 32'hc);
        settle();
        `CHK({pulse_out_a, pulse_out_b}, 2'b11)
        wr(tmo_pkg::ADDR_CTRL, 32'h1);
        wr(tmo_pkg::ADDR_ONESHOT, 32'h3);
        settle();
        `CHK({pulse_out_a, pulse_out_b}, 2'b00)
        n = 0;
        rdat = 32'h0;
        // Poll for match A; the bound keeps a dead counter from hanging here
        while (rdat[tmo_pkg::FLG_MATCH_A] !== 1'b1 && n < 50) begin
            rd(tmo_pkg::ADDR_FLAGS);
            n++;
        end
        settle();
        `CHK(rdat[tmo_pkg::FLG_MATCH_A], 1'b1)
        `CHK({pulse_out_a, pulse_out_b}, 2'b10)
        wr(tmo_pkg::ADDR_FLAGS, 32'h1);
        rd(tmo_pkg::ADDR_FLAGS);
        `CHK(rdat[tmo_pkg::FLG_MATCH_A], 1'b0)
        wr(tmo_pkg::ADDR_ONESHOT, 32'h8);
        settle();
        `CHK(pulse_out_b, 1'b1)
        wr(tmo_pkg::ADDR_ONESHOT, 32'h1);
        settle();
        `CHK(pulse_out_a, 1'b0)
        wr(tmo_pkg::ADDR_CTRL, 32'h0);
        settle();
        `CHK({pulse_out_a, pulse_out_b}, 2'b01)
        $display("test oneshot done");

        // Mid-run reset; the counter kept its value through the stop and must start at zero
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        `CHK({pulse_out_a, pulse_out_b}, 2'b11)

        // Pattern output, clear on B, every prescaler step; period 2 ticks, width 1 tick
        wr(tmo_pkg::ADDR_CMP_A, 32'h1);
        wr(tmo_pkg::ADDR_CMP_B, 32'h1);
        wr(tmo_pkg::ADDR_OUTCTL, 32'h00000013);
        for (int s = 0; s < 9; s++) begin
            wr(tmo_pkg::ADDR_CTRL, 32'h0);
            wr(tmo_pkg::ADDR_PRESC, 32'(s));
            wr(tmo_pkg::ADDR_CTRL, 32'h3);
            base = rises;
            n = 0;
            while (16'(rises - base) < 16'd2 && n < 20000) begin
                @(posedge hclk);
                n++;
            end
            `CHK(per, 16'(8 << s))
            `CHK(high, 16'(4 << s))
        end
        wr(tmo_pkg::ADDR_CTRL, 32'h0);
        settle();
        `CHK(pulse_out_a, 1'b1)
        $display("test pattern done");

        // Two-channel PWM, free running: each output falls at its own compare
        wr(tmo_pkg::ADDR_PRESC, 32'h0);
        wr(tmo_pkg::ADDR_CMP_A, 32'h5);
        wr(tmo_pkg::ADDR_CMP_B, 32'h20);
        wr(tmo_pkg::ADDR_OUTCTL, 32'h0000000f);
        wr(tmo_pkg::ADDR_FLAGS, 32'h7);
        wr(tmo_pkg::ADDR_CTRL, 32'h1);
        repeat (60) @(posedge hclk);
        #1;
        `CHK({pulse_out_a, pulse_out_b}, 2'b01)
        repeat (100) @(posedge hclk);
        rd(tmo_pkg::ADDR_FLAGS);
        `CHK(rdat[1:0], 2'b11)
        `CHK({pulse_out_a, pulse_out_b}, 2'b00)
        wr(tmo_pkg::ADDR_CTRL, 32'h0);
        $display("test pwm done");

        // Capture on both edges; a 2-clock glitch must vanish
        wr(tmo_pkg::ADDR_FLAGS, 32'h7);
        wr(tmo_pkg::ADDR_CTRL, 32'h00000019);
        pulse(16'd2, 20);
        rd(tmo_pkg::ADDR_FLAGS);
        `CHK(rdat[tmo_pkg::FLG_EDGE], 1'b0)
        rd(tmo_pkg::ADDR_CAPTURE);
        `CHK(rdat, 32'h00000000)
        pulse(16'd40, 15);
        rd(tmo_pkg::ADDR_CAPTURE);
        d1 = rdat;
        repeat (40) @(posedge hclk);
        rd(tmo_pkg::ADDR_CAPTURE);
        `CHK(rdat - d1, 32'h0000000a)
        rd(tmo_pkg::ADDR_FLAGS);
        `CHK(rdat[tmo_pkg::FLG_EDGE], 1'b1)
        $display("test capture done");
        close_out();
    end
endmodule // testbench
